/* File: core/sscd_top.sv */
// Purpose: start/stop command decoder of the drive input terminals
// Assumes: assignment and stop selection inputs are static, same clock domain
// Notes: terminal pins pass a two-flop synchroniser first
//
// Summary of operation
// - while second-set select is on, the whole alternative parameter set is selected by one flag
// - second-set select exists only on a terminal whose assignment code is 3
// - at setting 9999 forward and reverse inputs start their direction and removal ramps to stop
// - at settings 0 to 100 direct starts are kept and the motor coasts after that many seconds
// - at settings 1000 to 1100 the motor coasts after setting minus 1000 seconds
// - at 1000 to 1100 or 8888 forward is run and reverse is direction, low run stops
// - in two-wire mode exactly one input starts, both on or both off ramps to stop
// - with stop input on, a direction input pulsed on then off is latched as held start
// - releasing the stop input clears the held start and ramps to stop
// - stop input exists only on a terminal whose assignment code is 25
// - while jog is on, the stop input is ignored
// - output shutoff stops output without clearing the held start
// - forward start only via the forward assignment, reverse only via the reverse assignment
`timescale 1ns/1ps
module sscd_top #(
   parameter int unsigned TICKS_PER_SEC = sscd_pkg::TICKS_PER_UNIT
) (
   // clock and reset
   input wire logic CLOCK_IN,
   input wire logic SYS_RST_IN,
   // terminal pins
   input wire logic [sscd_pkg::TERM_COUNT-1:0] TERM_IN,
   // configuration
   input wire logic [7:0] FORWARD_TERMINAL_ASSIGN_PARAM_IN,
   input wire logic [7:0] REVERSE_TERMINAL_ASSIGN_PARAM_IN,
   input wire logic [7:0] AUX0_TERMINAL_ASSIGN_PARAM_IN,
   input wire logic [7:0] AUX1_TERMINAL_ASSIGN_PARAM_IN,
   input wire logic [7:0] AUX2_TERMINAL_ASSIGN_PARAM_IN,
   input wire logic [13:0] STOP_SELECTION_PARAM_IN,
   // commands
   output logic RUN_OUT,
   output logic REVERSE_OUT,
   output logic DECEL_OUT,
   output logic COAST_OUT,
   output logic SHUTOFF_OUT,
   output logic SECOND_SET_SELECT_OUT,
   output logic HOLD_ACTIVE_OUT
);

   // ****************************************
   // input synchronisation
   // ****************************************
   logic [sscd_pkg::TERM_COUNT-1:0] term_sync;

   sscd_sync #(
      .W(sscd_pkg::TERM_COUNT)
   ) u_sync (
      .clk_in(CLOCK_IN),
      .rst_in(SYS_RST_IN),
      .async_in(TERM_IN),
      .sync_out(term_sync)
   );

   // ****************************************
   // terminal function decode
   // ****************************************
   logic [7:0] assign_param [sscd_pkg::TERM_COUNT];
   sscd_pkg::sscd_fn_t fn;
   logic stop_assigned;

   always_comb begin
      assign_param[0] = FORWARD_TERMINAL_ASSIGN_PARAM_IN;
      assign_param[1] = REVERSE_TERMINAL_ASSIGN_PARAM_IN;
      assign_param[2] = AUX0_TERMINAL_ASSIGN_PARAM_IN;
      assign_param[3] = AUX1_TERMINAL_ASSIGN_PARAM_IN;
      assign_param[4] = AUX2_TERMINAL_ASSIGN_PARAM_IN;
   end

   always_comb begin
      fn = sscd_pkg::FN_RESET;
      stop_assigned = 1'b0;
      // start functions bound to their own terminals only
      fn.fwd = term_sync[sscd_pkg::TERM_FWD]
               & (assign_param[sscd_pkg::TERM_FWD] == sscd_pkg::FN_FORWARD);
      fn.rev = term_sync[sscd_pkg::TERM_REV]
               & (assign_param[sscd_pkg::TERM_REV] == sscd_pkg::FN_REVERSE);
      for (int i = 0; i < sscd_pkg::TERM_COUNT; i++) begin
         if (assign_param[i] == sscd_pkg::FN_STOP) begin
            stop_assigned = 1'b1;
            fn.stop = fn.stop | term_sync[i];
         end
         if (assign_param[i] == sscd_pkg::FN_SECOND_SET) begin
            fn.second_set = fn.second_set | term_sync[i];
         end
         if (assign_param[i] == sscd_pkg::FN_SHUTOFF) begin
            fn.shutoff = fn.shutoff | term_sync[i];
         end
         if (assign_param[i] == sscd_pkg::FN_JOG) begin
            fn.jog = fn.jog | term_sync[i];
         end
      end
   end

   // ****************************************
   // edge detection
   // ****************************************
   sscd_pkg::sscd_fn_t fn_q;
   sscd_pkg::sscd_fn_t fn_d;
   logic fwd_fall;
   logic rev_fall;

   always_comb begin
      fn_d = fn;
      fwd_fall = fn_q.fwd & ~fn.fwd;
      rev_fall = fn_q.rev & ~fn.rev;
   end

   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         fn_q <= sscd_pkg::FN_RESET;
      end else begin
         fn_q <= fn_d;
      end
   end

   // ****************************************
   // stop selection mode decode
   // ****************************************
   logic mode_time_coast;
   logic mode_rundir_coast;
   logic mode_rundir_decel;
   logic mode_rundir;
   logic mode_coast;
   logic [sscd_pkg::SEC_W-1:0] coast_seconds;
   logic [13:0] sel_minus_offset;

   always_comb begin
      mode_time_coast = (STOP_SELECTION_PARAM_IN <= sscd_pkg::SEL_COAST_MAX);
      mode_rundir_coast = (STOP_SELECTION_PARAM_IN >= sscd_pkg::SEL_RUNDIR_MIN)
                          && (STOP_SELECTION_PARAM_IN <= sscd_pkg::SEL_RUNDIR_MAX);
      mode_rundir_decel = (STOP_SELECTION_PARAM_IN == sscd_pkg::SEL_RUNDIR_DECEL);
      mode_rundir = mode_rundir_coast | mode_rundir_decel;
      mode_coast = mode_time_coast | mode_rundir_coast;
      sel_minus_offset = STOP_SELECTION_PARAM_IN - sscd_pkg::SEL_RUNDIR_MIN;
      if (mode_rundir_coast) begin
         coast_seconds = sel_minus_offset[sscd_pkg::SEC_W-1:0];
      end else begin
         coast_seconds = STOP_SELECTION_PARAM_IN[sscd_pkg::SEC_W-1:0];
      end
   end

   // ****************************************
   // three-wire self-hold
   // ****************************************
   logic three_wire;
   logic held_q;
   logic held_d;
   logic held_rev_q;
   logic held_rev_d;

   always_comb begin
      // jog disables the stop function entirely
      three_wire = stop_assigned & ~fn.jog & ~mode_rundir;
      held_d = held_q;
      held_rev_d = held_rev_q;
      if (!three_wire) begin
         held_d = 1'b0;
      end else if (!fn.stop) begin
         held_d = 1'b0;
      end else if (fwd_fall) begin
         held_d = 1'b1;
         held_rev_d = 1'b0;
      end else if (rev_fall) begin
         held_d = 1'b1;
         held_rev_d = 1'b1;
      end
      // shutoff deliberately takes no part here
   end

   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         held_q <= 1'b0;
         held_rev_q <= 1'b0;
      end else begin
         held_q <= held_d;
         held_rev_q <= held_rev_d;
      end
   end

   // ****************************************
   // run and direction command
   // ****************************************
   logic run_cmd;
   logic rev_cmd;

   always_comb begin
      if (mode_rundir) begin
         run_cmd = fn.fwd;
         rev_cmd = fn.rev;
      end else if (three_wire) begin
         run_cmd = held_d;
         rev_cmd = held_rev_d;
      end else begin
         run_cmd = fn.fwd ^ fn.rev;
         rev_cmd = fn.rev;
      end
   end

   // ****************************************
   // stop method state machine
   // ****************************************
   sscd_pkg::sscd_state_t state_q;
   sscd_pkg::sscd_state_t state_d;
   logic timer_start;
   logic timer_abort;
   logic timer_done;

   always_comb begin
      state_d = state_q;
      timer_start = 1'b0;
      timer_abort = 1'b0;
      case (state_q)
         sscd_pkg::ST_IDLE: begin
            if (run_cmd) begin
               state_d = sscd_pkg::ST_RUN;
            end
         end
         sscd_pkg::ST_RUN: begin
            if (!run_cmd) begin
               if (mode_coast) begin
                  state_d = sscd_pkg::ST_DELAY;
                  timer_start = 1'b1;
               end else begin
                  state_d = sscd_pkg::ST_RAMP;
               end
            end
         end
         sscd_pkg::ST_RAMP: begin
            if (run_cmd) begin
               state_d = sscd_pkg::ST_RUN;
            end
         end
         sscd_pkg::ST_DELAY: begin
            if (run_cmd) begin
               state_d = sscd_pkg::ST_RUN;
               timer_abort = 1'b1;
            end else if (timer_done) begin
               state_d = sscd_pkg::ST_COAST;
            end
         end
         sscd_pkg::ST_COAST: begin
            if (run_cmd) begin
               state_d = sscd_pkg::ST_RUN;
            end
         end
         default: begin
            state_d = sscd_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         state_q <= sscd_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   sscd_coast_timer #(
      .TICKS_PER_SEC(TICKS_PER_SEC)
   ) u_timer (
      .clk_in(CLOCK_IN),
      .rst_in(SYS_RST_IN),
      .start_in(timer_start),
      .abort_in(timer_abort),
      .seconds_in(coast_seconds),
      .done_out(timer_done)
   );

   // ****************************************
   // registered command outputs
   // ****************************************
   sscd_pkg::sscd_cmd_t cmd_q;
   sscd_pkg::sscd_cmd_t cmd_d;
   logic dir_q;
   logic dir_d;

   always_comb begin
      // direction remembered through the stop
      dir_d = run_cmd ? rev_cmd : dir_q;
      cmd_d = sscd_pkg::CMD_RESET;
      cmd_d.shutoff = fn.shutoff;
      cmd_d.run = (state_d == sscd_pkg::ST_RUN) & ~fn.shutoff;
      cmd_d.reverse = dir_d;
      cmd_d.decel = ((state_d == sscd_pkg::ST_RAMP) | (state_d == sscd_pkg::ST_DELAY))
                    & ~fn.shutoff;
      cmd_d.coast = (state_d == sscd_pkg::ST_COAST) | fn.shutoff;
      cmd_d.second_set = fn.second_set;
      cmd_d.held = held_d;
   end

   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         cmd_q <= sscd_pkg::CMD_RESET;
         dir_q <= 1'b0;
      end else begin
         cmd_q <= cmd_d;
         dir_q <= dir_d;
      end
   end

   // ****************************************
   // output drive
   // ****************************************
   assign RUN_OUT = cmd_q.run;
   assign REVERSE_OUT = cmd_q.reverse;
   assign DECEL_OUT = cmd_q.decel;
   assign COAST_OUT = cmd_q.coast;
   assign SHUTOFF_OUT = cmd_q.shutoff;
   assign SECOND_SET_SELECT_OUT = cmd_q.second_set;
   assign HOLD_ACTIVE_OUT = cmd_q.held;

endmodule

/* File: core/sscd_pkg.sv */
// Purpose: shared constants and types of the start/stop command decoder
// Assumes: terminal assignment codes and stop selection are static configuration
// Notes: all numbers live here once
package sscd_pkg;

   // ****************************************
   // stop selection settings
   // ****************************************
   localparam logic [13:0] SEL_DEFAULT = 14'h270F;
   localparam logic [13:0] SEL_RUNDIR_DECEL = 14'h22B8;
   localparam logic [13:0] SEL_COAST_MAX = 14'h0064;
   localparam logic [13:0] SEL_RUNDIR_MIN = 14'h03E8;
   localparam logic [13:0] SEL_RUNDIR_MAX = 14'h044C;

   // ****************************************
   // terminal function codes
   // ****************************************
   localparam logic [7:0] FN_SECOND_SET = 8'h03;
   localparam logic [7:0] FN_JOG = 8'h05;
   localparam logic [7:0] FN_SHUTOFF = 8'h18;
   localparam logic [7:0] FN_STOP = 8'h19;
   localparam logic [7:0] FN_FORWARD = 8'h3C;
   localparam logic [7:0] FN_REVERSE = 8'h3D;

   // ****************************************
   // terminals
   // ****************************************
   localparam int TERM_COUNT = 5;
   localparam int TERM_FWD = 0;
   localparam int TERM_REV = 1;
   localparam int SEC_W = 7;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned COAST_UNIT_S = 1;
   localparam int unsigned TICKS_PER_UNIT = CLK_HZ * COAST_UNIT_S;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RUN,
      ST_RAMP,
      ST_DELAY,
      ST_COAST
   } sscd_state_t;

   typedef struct packed {
      logic fwd;
      logic rev;
      logic stop;
      logic jog;
      logic shutoff;
      logic second_set;
   } sscd_fn_t;

   typedef struct packed {
      logic run;
      logic reverse;
      logic decel;
      logic coast;
      logic shutoff;
      logic second_set;
      logic held;
   } sscd_cmd_t;

   localparam sscd_fn_t FN_RESET = '0;
   localparam sscd_cmd_t CMD_RESET = '0;

endpackage

/* File: core/sscd_sync.sv */
// Purpose: two-flop synchroniser for terminal inputs
// Assumes: inputs are asynchronous levels
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module sscd_sync #(
   parameter int W = 5
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   // ****************************************
   // two stages
   // ****************************************
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule

/* File: core/sscd_coast_timer.sv */
// Purpose: delay in whole seconds before coasting
// Assumes: start and abort are single-cycle controls
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
module sscd_coast_timer #(
   parameter int unsigned TICKS_PER_SEC = sscd_pkg::TICKS_PER_UNIT
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // control
   input wire logic start_in,
   input wire logic abort_in,
   input wire logic [sscd_pkg::SEC_W-1:0] seconds_in,
   output logic done_out
);

   // ****************************************
   // state
   // ****************************************
   logic busy_q;
   logic busy_d;
   logic [31:0] presc_q;
   logic [31:0] presc_d;
   logic [sscd_pkg::SEC_W-1:0] sec_q;
   logic [sscd_pkg::SEC_W-1:0] sec_d;
   logic done_q;
   logic done_d;

   always_comb begin
      busy_d = busy_q;
      presc_d = presc_q;
      sec_d = sec_q;
      done_d = 1'b0;
      if (abort_in) begin
         busy_d = 1'b0;
      end else if (start_in) begin
         busy_d = 1'b1;
         presc_d = '0;
         sec_d = seconds_in;
      end else if (busy_q) begin
         if (sec_q == '0) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end else if (presc_q == 32'(TICKS_PER_SEC - 1)) begin
            presc_d = '0;
            sec_d = sec_q - 1'b1;
         end else begin
            presc_d = presc_q + 32'h00000001;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_q <= 1'b0;
         presc_q <= '0;
         sec_q <= '0;
         done_q <= 1'b0;
      end else begin
         busy_q <= busy_d;
         presc_q <= presc_d;
         sec_q <= sec_d;
         done_q <= done_d;
      end
   end

   assign done_out = done_q;

endmodule

/* File: sim/sscd_chk.sv */
// Purpose: port checker of the start/stop decoder
// Assumes: configuration static out of reset
// Notes: pin change shows three edges later
`timescale 1ns/1ps
module sscd_chk #(
   parameter int unsigned TICKS_PER_SEC = 10
) (
   // clock and reset
   input wire logic CLOCK_IN,
   input wire logic SYS_RST_IN,
   // terminals and configuration
   input wire logic [sscd_pkg::TERM_COUNT-1:0] TERM_IN,
   input wire logic [7:0] FORWARD_TERMINAL_ASSIGN_PARAM_IN,
   input wire logic [7:0] REVERSE_TERMINAL_ASSIGN_PARAM_IN,
   input wire logic [7:0] AUX0_TERMINAL_ASSIGN_PARAM_IN,
   input wire logic [7:0] AUX1_TERMINAL_ASSIGN_PARAM_IN,
   input wire logic [7:0] AUX2_TERMINAL_ASSIGN_PARAM_IN,
   input wire logic [13:0] STOP_SELECTION_PARAM_IN,
   // commands
   input wire logic RUN_OUT,
   input wire logic REVERSE_OUT,
   input wire logic DECEL_OUT,
   input wire logic COAST_OUT,
   input wire logic SHUTOFF_OUT,
   input wire logic SECOND_SET_SELECT_OUT,
   input wire logic HOLD_ACTIVE_OUT
);
   logic [4:0] p1_q, p2_q, p3_q, p4_q;
   logic [2:0] warm_q;
   int unsigned wait_q;
   int unsigned lo;
   logic [39:0] codes;
   logic [13:0] sel, nsec;
   logic warm, inr, rundir, coast_md, fwd3, rev3, ffall, rfall, stop3, jog3, shut3, sec3;
   function automatic logic hit(input logic [39:0] c, input logic [4:0] p, input logic [7:0] f);
      logic r;
      r = 1'h0;
      for (int i = 0; i < 5; i++) begin
         r = r | (p[i] & (c[8*i +: 8] == f));
      end
      return r;
   endfunction
   // ******
   // delayed pins and derived modes
   // ******
   assign codes = {AUX2_TERMINAL_ASSIGN_PARAM_IN, AUX1_TERMINAL_ASSIGN_PARAM_IN, AUX0_TERMINAL_ASSIGN_PARAM_IN,
                   REVERSE_TERMINAL_ASSIGN_PARAM_IN, FORWARD_TERMINAL_ASSIGN_PARAM_IN};
   assign sel = STOP_SELECTION_PARAM_IN;
   assign warm = warm_q == 3'h5;
   assign inr = sel >= sscd_pkg::SEL_RUNDIR_MIN && sel <= sscd_pkg::SEL_RUNDIR_MAX;
   assign rundir = inr || sel == sscd_pkg::SEL_RUNDIR_DECEL;
   assign coast_md = inr || sel <= sscd_pkg::SEL_COAST_MAX;
   assign nsec = inr ? sel - sscd_pkg::SEL_RUNDIR_MIN : sel;
   assign lo = nsec * TICKS_PER_SEC;
   assign fwd3 = p3_q[0] & (FORWARD_TERMINAL_ASSIGN_PARAM_IN == sscd_pkg::FN_FORWARD);
   assign rev3 = p3_q[1] & (REVERSE_TERMINAL_ASSIGN_PARAM_IN == sscd_pkg::FN_REVERSE);
   assign ffall = p4_q[0] & !fwd3 & (FORWARD_TERMINAL_ASSIGN_PARAM_IN == sscd_pkg::FN_FORWARD);
   assign rfall = p4_q[1] & !rev3 & (REVERSE_TERMINAL_ASSIGN_PARAM_IN == sscd_pkg::FN_REVERSE);
   assign stop3 = hit(codes, p3_q, sscd_pkg::FN_STOP);
   assign jog3 = hit(codes, p3_q, sscd_pkg::FN_JOG);
   assign shut3 = hit(codes, p3_q, sscd_pkg::FN_SHUTOFF);
   assign sec3 = hit(codes, p3_q, sscd_pkg::FN_SECOND_SET);
   always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         {p1_q, p2_q, p3_q, p4_q} <= '0;
         warm_q <= 3'h0;
         wait_q <= 0;
      end else begin
         {p1_q, p2_q, p3_q, p4_q} <= {TERM_IN, p1_q, p2_q, p3_q};
         warm_q <= warm ? warm_q : warm_q + 3'h1;
         wait_q <= RUN_OUT ? 0 : wait_q + DECEL_OUT;
      end
   end
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (SYS_RST_IN);
   // ******
   // assertions
   // ******
   two_wire_a:
      assert property (warm && !rundir && !hit(codes, 5'h1F, sscd_pkg::FN_STOP) |->
         RUN_OUT == ((fwd3 ^ rev3) & !shut3) && (!RUN_OUT || REVERSE_OUT == rev3)) else $error("two-wire run");
   run_dir_a:
      assert property (warm && rundir |-> RUN_OUT == (fwd3 & !shut3) && (!RUN_OUT || REVERSE_OUT == rev3))
         else $error("run/dir run");
   second_set_a:
      assert property (warm |-> SECOND_SET_SELECT_OUT == sec3) else $error("second set");
   shutoff_force_a:
      assert property (warm |-> SHUTOFF_OUT == shut3 && (!SHUTOFF_OUT || COAST_OUT && !RUN_OUT && !DECEL_OUT))
         else $error("shutoff");
   stop_ramp_a:
      assert property (warm && $fell(RUN_OUT) && !SHUTOFF_OUT |-> DECEL_OUT) else $error("no ramp");
   coast_time_a:
      assert property (warm && coast_md && !SHUTOFF_OUT && !$past(SHUTOFF_OUT) && $rose(COAST_OUT) |->
         wait_q + 2 >= lo && wait_q <= lo + 4) else $error("coast early");
   coast_bound_a:
      assert property (warm && coast_md && DECEL_OUT |-> wait_q <= lo + 4) else $error("coast late");
   hold_start_a:
      assert property (warm && !rundir && stop3 && !jog3 && !shut3 && (ffall || rfall) |->
         HOLD_ACTIVE_OUT && RUN_OUT && REVERSE_OUT == !ffall) else $error("hold start");
   hold_keep_a:
      assert property (warm && !rundir && $past(HOLD_ACTIVE_OUT) && stop3 && !jog3 |->
         HOLD_ACTIVE_OUT && RUN_OUT == !shut3) else $error("hold lost");
   hold_clear_a:
      assert property (warm && $past(HOLD_ACTIVE_OUT) && !stop3 && !jog3 && !shut3 && !fwd3 && !rev3 |->
         !HOLD_ACTIVE_OUT && DECEL_OUT && !RUN_OUT) else $error("hold kept");
   jog_ignore_a:
      assert property (warm && jog3 && !$past(HOLD_ACTIVE_OUT) |-> !HOLD_ACTIVE_OUT) else $error("jog hold");
endmodule
bind sscd_top sscd_chk #(.TICKS_PER_SEC(TICKS_PER_SEC)) i_chk (.CLOCK_IN(CLOCK_IN), .SYS_RST_IN(SYS_RST_IN),
   .TERM_IN(TERM_IN), .FORWARD_TERMINAL_ASSIGN_PARAM_IN(FORWARD_TERMINAL_ASSIGN_PARAM_IN),
   .REVERSE_TERMINAL_ASSIGN_PARAM_IN(REVERSE_TERMINAL_ASSIGN_PARAM_IN),
   .AUX0_TERMINAL_ASSIGN_PARAM_IN(AUX0_TERMINAL_ASSIGN_PARAM_IN),
   .AUX1_TERMINAL_ASSIGN_PARAM_IN(AUX1_TERMINAL_ASSIGN_PARAM_IN),
   .AUX2_TERMINAL_ASSIGN_PARAM_IN(AUX2_TERMINAL_ASSIGN_PARAM_IN), .STOP_SELECTION_PARAM_IN(STOP_SELECTION_PARAM_IN),
   .RUN_OUT(RUN_OUT), .REVERSE_OUT(REVERSE_OUT), .DECEL_OUT(DECEL_OUT), .COAST_OUT(COAST_OUT),
   .SHUTOFF_OUT(SHUTOFF_OUT), .SECOND_SET_SELECT_OUT(SECOND_SET_SELECT_OUT), .HOLD_ACTIVE_OUT(HOLD_ACTIVE_OUT));

/* File: sim/sscd_switches.sv */
// Purpose: external switches on the terminal pins
// Assumes: bench commands the levels
// Notes: pins change just after a rising edge
`timescale 1ns/1ps
module sscd_switches (
   // clock
   input wire logic clk_in,
   // terminal pins
   output logic [4:0] pins_out
);
   initial pins_out = 5'h00;
   task automatic put(input logic [4:0] v);
      @(posedge clk_in);
      pins_out <= v;
   endtask
   // start pulse on then off, also turns a held start round
   task automatic pulse(input logic [4:0] base, input int idx, input int len);
      put(base | (5'h01 << idx));
      repeat (len) @(posedge clk_in);
      put(base);
   endtask
endmodule

/* File: sim/tb.sv */
// Purpose: self-checking bench of the start/stop decoder
// Assumes: short seconds via TICKS_PER_SEC
// Notes: each output change is matched to a queued note
`timescale 1ns/1ps
module tb;
   localparam int unsigned TPS = 10;
   localparam logic [6:0] RN = 7'h40, RV = 7'h20, DC = 7'h10, CS = 7'h08, SH = 7'h04, SS = 7'h02, HD = 7'h01;
   localparam logic [7:0] FF = sscd_pkg::FN_FORWARD, FR = sscd_pkg::FN_REVERSE;
   logic clk, rst, noise, cm;
   logic [4:0] pins, pins_v;
   logic [7:0] cf, cr, ca0, ca1, ca2;
   logic [13:0] sel, n;
   wire [6:0] outs;
   logic [6:0] last;
   logic [6:0] expq[$];
   logic [31:0] seed = 32'h85F5;
   logic [13:0] tbl[9] = '{14'h0000, 14'h0001, 14'h0064, 14'h03E8, 14'h03EA, 14'h044C, 14'h22B8, 14'h270F, 14'h0065};
   int fail_count = 0;
   int total_checks = 0;
   sscd_switches i_sw (.clk_in(clk), .pins_out(pins));
   sscd_top #(.TICKS_PER_SEC(TPS)) i_dut (.CLOCK_IN(clk), .SYS_RST_IN(rst), .TERM_IN(pins),
      .FORWARD_TERMINAL_ASSIGN_PARAM_IN(cf), .REVERSE_TERMINAL_ASSIGN_PARAM_IN(cr),
      .AUX0_TERMINAL_ASSIGN_PARAM_IN(ca0), .AUX1_TERMINAL_ASSIGN_PARAM_IN(ca1),
      .AUX2_TERMINAL_ASSIGN_PARAM_IN(ca2), .STOP_SELECTION_PARAM_IN(sel), .RUN_OUT(outs[6]),
      .REVERSE_OUT(outs[5]), .DECEL_OUT(outs[4]), .COAST_OUT(outs[3]), .SHUTOFF_OUT(outs[2]),
      .SECOND_SET_SELECT_OUT(outs[1]), .HOLD_ACTIVE_OUT(outs[0]));
   // ******
   // helpers
   // ******
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic cmp_cmd(input logic [6:0] e, input logic [6:0] g);
      total_checks++;
      if (e !== g) begin
         fail_count++;
         $display("mismatch at %0t: expected %0h got %0h", $time, e, g);
      end
   endtask
   task automatic end_of_test();
      if (fail_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic do_reset(input logic [13:0] s, input logic [39:0] c);
      @(posedge clk);
      rst <= 1'h1;
      sel <= s;
      {ca2, ca1, ca0, cr, cf} <= c;
      pins_v = 5'h00;
      i_sw.put(5'h00);
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      repeat (4) @(posedge clk);
   endtask
   // e[7] set: the pin change must show e[6:0]
   task automatic step(input int idx, input logic v, input logic [7:0] e);
      if (e[7]) expq.push_back(e[6:0]);
      pins_v[idx] = v;
      seed = xs(seed);
      if (noise) pins_v[4:2] = seed[6:4];
      i_sw.put(pins_v);
      repeat (6 + seed[3:0]) @(posedge clk);
   endtask
   task automatic hold(input int idx, input logic [6:0] e);
      expq.push_back(e);
      seed = xs(seed);
      i_sw.pulse(pins_v, idx, 3 + seed[2:0]);
      repeat (10) @(posedge clk);
   endtask
   // ******
   // clock, watcher, watchdog
   // ******
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(negedge clk) begin
      if (rst) begin
         last = 7'h00;
      end else if (outs !== last) begin
         last = outs;
         if (expq.size() == 0) cmp_cmd({7{1'hx}}, outs);
         else cmp_cmd(expq.pop_front(), outs);
      end
   end
   initial begin
      repeat (40000) @(posedge clk);
      fail_count++;
      end_of_test();
   end
   // ******
   // scenarios
   // ******
   initial begin
      rst = 1'h1;
      noise = 1'h0;
      sel = sscd_pkg::SEL_DEFAULT;
      {ca2, ca1, ca0, cr, cf} = '0;
      do_reset(sscd_pkg::SEL_DEFAULT, {8'h3C, sscd_pkg::FN_SHUTOFF, sscd_pkg::FN_SECOND_SET, FR, FF});
      step(0, 1'h1, {1'h1, RN});
      step(4, 1'h1, 8'h00);
      step(4, 1'h0, 8'h00);
      step(1, 1'h1, {1'h1, DC});
      step(0, 1'h0, {1'h1, RN | RV});
      step(1, 1'h0, {1'h1, RV | DC});
      step(2, 1'h1, {1'h1, RV | DC | SS});
      step(2, 1'h0, {1'h1, RV | DC});
      step(1, 1'h1, {1'h1, RN | RV});
      step(3, 1'h1, {1'h1, RV | CS | SH});
      step(3, 1'h0, {1'h1, RN | RV});
      step(1, 1'h0, {1'h1, RV | DC});
      do_reset(sscd_pkg::SEL_RUNDIR_DECEL, {24'h000000, FR, FF});
      step(0, 1'h1, {1'h1, RN});
      step(1, 1'h1, {1'h1, RN | RV});
      step(0, 1'h0, {1'h1, RV | DC});
      step(0, 1'h1, {1'h1, RN | RV});
      step(1, 1'h0, {1'h1, RN});
      step(0, 1'h0, {1'h1, DC});
      do_reset(sscd_pkg::SEL_DEFAULT, {sscd_pkg::FN_JOG, sscd_pkg::FN_SHUTOFF, sscd_pkg::FN_STOP, FR, FF});
      step(2, 1'h1, 8'h00);
      hold(0, RN | HD);
      hold(1, RN | RV | HD);
      step(3, 1'h1, {1'h1, RV | CS | SH | HD});
      step(3, 1'h0, {1'h1, RN | RV | HD});
      step(2, 1'h0, {1'h1, RV | DC});
      step(4, 1'h1, 8'h00);
      step(2, 1'h1, 8'h00);
      step(0, 1'h1, {1'h1, RN});
      step(0, 1'h0, {1'h1, DC});
      cmp_cmd(7'h00, 7'(expq.size()));
      noise = 1'h1;
      foreach (tbl[k]) begin
         do_reset(tbl[k], {24'h000000, FR, FF});
         cm = tbl[k] <= sscd_pkg::SEL_COAST_MAX ||
              (tbl[k] >= sscd_pkg::SEL_RUNDIR_MIN && tbl[k] <= sscd_pkg::SEL_RUNDIR_MAX);
         n = tbl[k] >= sscd_pkg::SEL_RUNDIR_MIN ? tbl[k] - sscd_pkg::SEL_RUNDIR_MIN : tbl[k];
         step(0, 1'h1, {1'h1, RN});
         if (cm) begin
            expq.push_back(DC);
            step(0, 1'h0, {1'h1, CS});
            repeat (n * TPS + 20) @(posedge clk);
         end else begin
            step(0, 1'h0, {1'h1, DC});
         end
         cmp_cmd(7'h00, 7'(expq.size()));
      end
      end_of_test();
   end
endmodule
